// [rtl/odsc_consts.vh]
`ifndef ODSC_CONSTS_VH
`define ODSC_CONSTS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define ODSC_ADDR_LINE 12'h000
`define ODSC_ADDR_HOST 12'h004
`define ODSC_ADDR_STAT 12'h008
`define ODSC_ADDR_INT 12'h00c
`define ODSC_ADDR_STATE 12'h010
`define ODSC_ADDR_NOM 12'h014
`define ODSC_ADDR_EDGE 12'h018
// ****************************************
// Line control fields
// ****************************************
`define ODSC_LC_AMP_OVR 0
`define ODSC_LC_AMP_LO 1
`define ODSC_LC_AMP_HI 2
`define ODSC_LC_AUTO_DIS 4
`define ODSC_LC_EMPH_MAN 5
`define ODSC_LC_EMPH_LO 8
`define ODSC_LC_EMPH_HI 11
`define ODSC_LC_INV_A 12
`define ODSC_LC_INV_B 13
`define ODSC_LC_INV_HOST 14
`define ODSC_LC_RESET 32'h0000_0000
// ****************************************
// Host loop-back fields and defaults
// ****************************************
`define ODSC_HC_SWING_LO 0
`define ODSC_HC_SWING_HI 11
`define ODSC_HC_DEEMPH_LO 16
`define ODSC_HC_DEEMPH_HI 23
`define ODSC_HC_REG_EN 31
`define ODSC_HOST_SWING_MV 12'h23a
`define ODSC_HOST_DEEMPH_TENTH_DB 8'h04
`define ODSC_LINE_NOM_MV 12'h320
// ****************************************
// Status pin configuration
// ****************************************
`define ODSC_SC_FN_LO 0
`define ODSC_SC_FN_HI 1
`define ODSC_SC_MASK_LO 4
`define ODSC_SC_MASK_HI 8
`define ODSC_FN_LOCK 2'h0
`define ODSC_FN_SIGNAL 2'h1
`define ODSC_FN_INT 2'h2
// ****************************************
// Interrupt source bits
// ****************************************
`define ODSC_IRQ_LOST_SET 0
`define ODSC_IRQ_LOST_CLR 1
`define ODSC_IRQ_EYE 2
`define ODSC_IRQ_LOCK_GAIN 3
`define ODSC_IRQ_LOCK_LOSS 4
// ****************************************
// Detected rate codes and edge times in ps
// ****************************************
`define ODSC_RATE_12G 3'h0
`define ODSC_RATE_6G 3'h1
`define ODSC_RATE_3G 3'h2
`define ODSC_RATE_1G5 3'h3
`define ODSC_RATE_270M 3'h4
`define ODSC_EDGE_12G 10'h022
`define ODSC_EDGE_6G 10'h024
`define ODSC_EDGE_3G 10'h03b
`define ODSC_EDGE_1G5 10'h03c
`define ODSC_EDGE_270M 10'h226
// ****************************************
// Four-level strap codes
// ****************************************
`define ODSC_LVL_LOW 2'h0
`define ODSC_LVL_RES 2'h1
`define ODSC_LVL_FLOAT 2'h2
`define ODSC_LVL_HIGH 2'h3
`define ODSC_CMP_LOW 3'h0
`define ODSC_CMP_RES 3'h1
`define ODSC_CMP_FLOAT 3'h3
`define ODSC_CMP_HIGH 3'h7
`endif

// [rtl/odsc_strap.v]
`timescale 1ns/100ps
`default_nettype none
`include "odsc_consts.vh"
// ****************************************
// Four-level strap decoder
// ****************************************
module odsc_strap (
    input wire clk,
    input wire rst,
    input wire capture,
    input wire [2:0] cmp,
    output reg [1:0] level
);
    // Thermometer code from three pad comparators; a broken code reads as float
    function [1:0] decode;
        input [2:0] c;
        begin
            case (c)
                `ODSC_CMP_LOW: decode = `ODSC_LVL_LOW;
                `ODSC_CMP_RES: decode = `ODSC_LVL_RES;
                `ODSC_CMP_HIGH: decode = `ODSC_LVL_HIGH;
                default: decode = `ODSC_LVL_FLOAT;
            endcase
        end
    endfunction

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= `ODSC_LVL_FLOAT;
        end else if (capture) begin
            level <= decode(cmp);
        end
    end
endmodule // odsc_strap
`default_nettype wire

// [rtl/odsc_top.v]
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "odsc_consts.vh"
module odsc_top (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [2:0] line_amplitude_strap,
    input wire [2:0] mode_strap,
    input wire recovered_data,
    input wire clock_recovery_locked,
    input wire [2:0] detected_rate,
    input wire reclock_bypass,
    input wire signal_found_n,
    input wire adapt_done,
    input wire input_lost,
    input wire eye_low,
    output reg line_out_a,
    output reg line_out_b,
    output reg host_loopback_out,
    output reg [1:0] output_swing_level,
    output reg [11:0] line_nominal_mv,
    output reg line_emph_en,
    output reg [3:0] line_emph_amount,
    output reg [9:0] line_edge_ps,
    output reg [11:0] host_swing_mv,
    output reg [7:0] host_deemph_tenth_db,
    output reg status_out,
    output reg status_oe,
    output reg spi_select,
    output reg smbus_select,
    output reg mode_reserved
);
    // ****************************************
    // Functions
    // ****************************************
    function [9:0] edge_for_rate;
        input [2:0] r;
        begin
            case (r)
                `ODSC_RATE_12G: edge_for_rate = `ODSC_EDGE_12G;
                `ODSC_RATE_6G: edge_for_rate = `ODSC_EDGE_6G;
                `ODSC_RATE_3G: edge_for_rate = `ODSC_EDGE_3G;
                `ODSC_RATE_1G5: edge_for_rate = `ODSC_EDGE_1G5;
                default: edge_for_rate = `ODSC_EDGE_270M;
            endcase
        end
    endfunction

    function rate_is_uhd;
        input [2:0] r;
        begin
            rate_is_uhd = (r == `ODSC_RATE_12G) || (r == `ODSC_RATE_6G);
        end
    endfunction

    // ****************************************
    // Registers and state
    // ****************************************
    reg [31:0] line_ctrl;
    reg [31:0] host_ctrl;
    reg [31:0] stat_cfg;
    reg [4:0] int_flags;
    reg [11:0] nominal;
    reg [9:0] edge_man;
    reg started;
    reg mode_done;
    reg lock_prev;
    reg lost_prev;
    reg eye_prev;
    reg [2:0] held_rate;
    reg held_valid;
    wire [1:0] amp_strap_level;
    wire [1:0] mode_level;
    wire capture;
    wire bus_access;
    wire bus_write;
    wire bus_read;
    wire int_read;
    wire [4:0] events;
    wire [4:0] mask;
    wire [1:0] status_fn;
    wire auto_on;
    wire sig_ok;
    reg status_assert;
    reg [31:0] next_rdata;
    reg next_err;

    // Straps are caught once, on the first edge after reset release
    assign capture = ~started;

    odsc_strap u_amp_strap (
        .clk(clk),
        .rst(rst),
        .capture(capture),
        .cmp(line_amplitude_strap),
        .level(amp_strap_level)
    );

    odsc_strap u_mode_strap (
        .clk(clk),
        .rst(rst),
        .capture(capture),
        .cmp(mode_strap),
        .level(mode_level)
    );

    // ****************************************
    // APB slave
    // ****************************************
    // One wait state: pready rises one edge into the access phase
    assign bus_access = psel & penable & pready;
    assign bus_write = bus_access & pwrite;
    assign bus_read = bus_access & ~pwrite;
    assign int_read = bus_read & (paddr == `ODSC_ADDR_INT);

    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        case (paddr)
            `ODSC_ADDR_LINE: next_rdata = line_ctrl;
            `ODSC_ADDR_HOST: next_rdata = host_ctrl;
            `ODSC_ADDR_STAT: next_rdata = stat_cfg;
            `ODSC_ADDR_INT: next_rdata = {27'h0000000, int_flags};
            `ODSC_ADDR_STATE: begin
                next_rdata = {12'h000, line_edge_ps, line_emph_en,
                    held_rate, mode_level, amp_strap_level,
                    sig_ok, clock_recovery_locked};
            end
            `ODSC_ADDR_NOM: next_rdata = {20'h00000, nominal};
            `ODSC_ADDR_EDGE: next_rdata = {22'h000000, edge_man};
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
            if (psel & penable & ~pready) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_err;
            end else begin
                prdata <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            line_ctrl <= `ODSC_LC_RESET;
            host_ctrl <= {8'h00, `ODSC_HOST_DEEMPH_TENTH_DB,
                4'h0, `ODSC_HOST_SWING_MV};
            stat_cfg <= 32'h0000_0000;
            nominal <= `ODSC_LINE_NOM_MV;
            edge_man <= `ODSC_EDGE_270M;
        end else if (bus_write) begin
            case (paddr)
                `ODSC_ADDR_LINE: line_ctrl <= pwdata & 32'h0000_7f37;
                `ODSC_ADDR_HOST: host_ctrl <= pwdata & 32'h80ff_0fff;
                `ODSC_ADDR_STAT: stat_cfg <= pwdata & 32'h0000_01f3;
                `ODSC_ADDR_NOM: nominal <= pwdata[11:0];
                `ODSC_ADDR_EDGE: edge_man <= pwdata[9:0];
                default: nominal <= nominal;
            endcase
        end
    end

    // ****************************************
    // Power-up strap and interface select
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            started <= 1'b0;
            mode_done <= 1'b0;
            spi_select <= 1'b0;
            smbus_select <= 1'b0;
            mode_reserved <= 1'b0;
        end else begin
            started <= 1'b1;
            // Level becomes valid one edge after capture
            mode_done <= started;
            if (started & ~mode_done) begin
                spi_select <= (mode_level == `ODSC_LVL_FLOAT);
                smbus_select <= (mode_level == `ODSC_LVL_LOW);
                mode_reserved <= (mode_level == `ODSC_LVL_HIGH) ||
                    (mode_level == `ODSC_LVL_RES);
            end
        end
    end

    // ****************************************
    // Rate tracking and automatic choices
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            held_rate <= `ODSC_RATE_270M;
            held_valid <= 1'b0;
        end else if (clock_recovery_locked & ~reclock_bypass) begin
            if (~lock_prev | (detected_rate != held_rate)) begin
                held_rate <= detected_rate;
            end
            held_valid <= 1'b1;
        end else if (reclock_bypass) begin
            held_valid <= 1'b0;
        end
    end

    // Bypass or a disabled auto bit hands pre-emphasis to software
    assign auto_on = ~reclock_bypass & ~line_ctrl[`ODSC_LC_AUTO_DIS];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            output_swing_level <= `ODSC_LVL_FLOAT;
            line_nominal_mv <= `ODSC_LINE_NOM_MV;
            line_emph_en <= 1'b0;
            line_emph_amount <= 4'h0;
            line_edge_ps <= `ODSC_EDGE_270M;
            host_swing_mv <= `ODSC_HOST_SWING_MV;
            host_deemph_tenth_db <= `ODSC_HOST_DEEMPH_TENTH_DB;
        end else begin
            // Level code: high +5, float nominal, resistor +10, low -5 percent
            if (line_ctrl[`ODSC_LC_AMP_OVR]) begin
                output_swing_level <=
                    line_ctrl[`ODSC_LC_AMP_HI:`ODSC_LC_AMP_LO];
            end else begin
                output_swing_level <= amp_strap_level;
            end
            line_nominal_mv <= nominal;
            if (auto_on) begin
                line_emph_en <= held_valid & rate_is_uhd(held_rate);
            end else begin
                line_emph_en <= line_ctrl[`ODSC_LC_EMPH_MAN];
            end
            line_emph_amount <=
                line_ctrl[`ODSC_LC_EMPH_HI:`ODSC_LC_EMPH_LO];
            if (reclock_bypass) begin
                line_edge_ps <= edge_man;
            end else begin
                line_edge_ps <= edge_for_rate(held_rate);
            end
            if (host_ctrl[`ODSC_HC_REG_EN]) begin
                host_swing_mv <=
                    host_ctrl[`ODSC_HC_SWING_HI:`ODSC_HC_SWING_LO];
                host_deemph_tenth_db <=
                    host_ctrl[`ODSC_HC_DEEMPH_HI:`ODSC_HC_DEEMPH_LO];
            end else begin
                host_swing_mv <= `ODSC_HOST_SWING_MV;
                host_deemph_tenth_db <= `ODSC_HOST_DEEMPH_TENTH_DB;
            end
        end
    end

    // ****************************************
    // Data outputs with polarity control
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            line_out_a <= 1'b0;
            line_out_b <= 1'b0;
            host_loopback_out <= 1'b0;
        end else begin
            line_out_a <= recovered_data ^ line_ctrl[`ODSC_LC_INV_A];
            line_out_b <= recovered_data ^ line_ctrl[`ODSC_LC_INV_B];
            host_loopback_out <=
                recovered_data ^ line_ctrl[`ODSC_LC_INV_HOST];
        end
    end

    // ****************************************
    // Interrupt events and sticky flags
    // ****************************************
    assign events[`ODSC_IRQ_LOST_SET] = input_lost & ~lost_prev;
    assign events[`ODSC_IRQ_LOST_CLR] = ~input_lost & lost_prev;
    // Eye checks only mean anything once the recovered clock is locked
    assign events[`ODSC_IRQ_EYE] = eye_low & ~eye_prev & clock_recovery_locked;
    assign events[`ODSC_IRQ_LOCK_GAIN] = clock_recovery_locked & ~lock_prev;
    assign events[`ODSC_IRQ_LOCK_LOSS] = ~clock_recovery_locked & lock_prev;
    assign mask = stat_cfg[`ODSC_SC_MASK_HI:`ODSC_SC_MASK_LO];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_prev <= 1'b0;
            lost_prev <= 1'b0;
            eye_prev <= 1'b0;
            int_flags <= 5'h00;
        end else begin
            lock_prev <= clock_recovery_locked;
            lost_prev <= input_lost;
            eye_prev <= eye_low;
            // A new event in the read cycle survives the clear
            if (int_read) begin
                int_flags <= events & mask;
            end else begin
                int_flags <= int_flags | (events & mask);
            end
        end
    end

    // ****************************************
    // Status pin
    // ****************************************
    assign status_fn = stat_cfg[`ODSC_SC_FN_HI:`ODSC_SC_FN_LO];
    assign sig_ok = ~signal_found_n & adapt_done;

    always @* begin
        case (status_fn)
            `ODSC_FN_SIGNAL: status_assert = sig_ok;
            `ODSC_FN_INT: status_assert = |int_flags;
            default: status_assert = clock_recovery_locked;
        endcase
    end

    // Open drain: the pin is only ever pulled low, never driven high
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            status_out <= 1'b0;
            status_oe <= 1'b0;
        end else begin
            status_out <= 1'b0;
            status_oe <= status_assert;
        end
    end
endmodule // odsc_top
`default_nettype wire

// [bench/odsc_partner.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Far side: cable receivers and status pull-up
// ****************************************
module odsc_partner (
    input wire logic clk,
    input wire logic line_out_a,
    input wire logic line_out_b,
    input wire logic host_loopback_out,
    input wire logic status_out,
    input wire logic status_oe,
    output var logic rx_a,
    output var logic rx_b,
    output var logic rx_host,
    output wire logic pin
);
    // Pull-up wins whenever the pin is released
    assign pin = status_oe ? status_out : 1'b1;
    // Receivers sample all three lanes on the same edge so lane skew stays visible
    always @(posedge clk) begin
        rx_a <= line_out_a;
        rx_b <= line_out_b;
        rx_host <= host_loopback_out;
    end
endmodule // odsc_partner
`default_nettype wire

// [bench/odsc_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "odsc_consts.vh"
// ****************************************
// Port checker
// ****************************************
module odsc_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic recovered_data,
    input wire logic clock_recovery_locked,
    input wire logic reclock_bypass,
    input wire logic signal_found_n,
    input wire logic adapt_done,
    input wire logic line_out_a,
    input wire logic line_out_b,
    input wire logic host_loopback_out,
    input wire logic line_emph_en,
    input wire logic [11:0] host_swing_mv,
    input wire logic [7:0] host_deemph_tenth_db,
    input wire logic status_out,
    input wire logic status_oe,
    input wire logic spi_select,
    input wire logic smbus_select
);
    logic [2:0] inv;
    logic [1:0] fn;
    logic host_en;
    logic emph_man;
    wire logic wr_done = psel && penable && pready && pwrite;
    wire logic rd_int = psel && penable && pready && !pwrite && paddr == `ODSC_ADDR_INT;
    wire logic fn_lock = fn == `ODSC_FN_LOCK || fn == 2'h3;
    // Shadow of the control bits, taken from completed writes only
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            inv <= 3'h0;
            fn <= 2'h0;
            host_en <= 1'b0;
            emph_man <= 1'b0;
        end else if (wr_done) begin
            if (paddr == `ODSC_ADDR_LINE) begin
                inv <= pwdata[14:12];
                emph_man <= pwdata[5];
            end
            if (paddr == `ODSC_ADDR_HOST) host_en <= pwdata[31];
            if (paddr == `ODSC_ADDR_STAT) fn <= pwdata[1:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_inv_a;
        !$past(rst) && inv == $past(inv) |-> line_out_a == ($past(recovered_data) ^ inv[0]);
    endproperty
    a_inv_a: assert property (p_inv_a) else $error("lane a polarity wrong");
    property p_inv_b;
        !$past(rst) && inv == $past(inv) |-> line_out_b == ($past(recovered_data) ^ inv[1]);
    endproperty
    a_inv_b: assert property (p_inv_b) else $error("lane b polarity wrong");
    property p_inv_host;
        !$past(rst) && inv == $past(inv) |-> host_loopback_out == ($past(recovered_data) ^ inv[2]);
    endproperty
    a_inv_host: assert property (p_inv_host) else $error("loop-back data wrong");
    property p_lock;
        !$past(rst) && fn_lock && $past(fn_lock) |-> status_oe == $past(clock_recovery_locked);
    endproperty
    a_lock: assert property (p_lock) else $error("lock pin wrong");
    property p_signal;
        !$past(rst) && fn == `ODSC_FN_SIGNAL && $past(fn) == `ODSC_FN_SIGNAL
            |-> status_oe == $past(!signal_found_n && adapt_done);
    endproperty
    a_signal: assert property (p_signal) else $error("signal pin wrong");
    property p_open_drain;
        status_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_host_default;
        !host_en && !$past(host_en) |-> host_swing_mv == `ODSC_HOST_SWING_MV
            && host_deemph_tenth_db == `ODSC_HOST_DEEMPH_TENTH_DB;
    endproperty
    a_host_default: assert property (p_host_default) else $error("loop-back default lost");
    // Flag raised in interrupt mode with no interrupt register read this or last cycle
    sequence s_flag_held;
        status_oe && fn == `ODSC_FN_INT && $past(fn) == `ODSC_FN_INT && !rd_int && !$past(rd_int);
    endsequence
    property p_sticky;
        s_flag_held |=> status_oe;
    endproperty
    a_sticky: assert property (p_sticky) else $error("interrupt not sticky");
    property p_mode_sel;
        !(spi_select && smbus_select);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("two interfaces selected");
    property p_bypass_emph;
        reclock_bypass && $past(reclock_bypass) && $past(reclock_bypass, 2)
            && emph_man == $past(emph_man) && emph_man == $past(emph_man, 2)
            |-> line_emph_en == emph_man;
    endproperty
    a_bypass_emph: assert property (p_bypass_emph) else $error("manual emphasis ignored");
endmodule // odsc_monitor
bind odsc_top odsc_monitor odsc_monitor_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .recovered_data, .clock_recovery_locked, .reclock_bypass,
    .signal_found_n, .adapt_done, .line_out_a, .line_out_b, .host_loopback_out,
    .line_emph_en, .host_swing_mv, .host_deemph_tenth_db, .status_out, .status_oe,
    .spi_select, .smbus_select);
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "odsc_consts.vh"
// ****************************************
// Testbench
// ****************************************
module testbench;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] line_amplitude_strap = 3'h3, mode_strap = 3'h3, detected_rate = 3'h0;
    logic recovered_data = 1'b0, clock_recovery_locked = 1'b0, reclock_bypass = 1'b0;
    logic signal_found_n = 1'b1, adapt_done = 1'b0, input_lost = 1'b0, eye_low = 1'b0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, line_out_a, line_out_b, host_loopback_out, line_emph_en;
    wire logic status_out, status_oe, spi_select, smbus_select, mode_reserved;
    wire logic [1:0] output_swing_level;
    wire logic [11:0] line_nominal_mv, host_swing_mv;
    wire logic [3:0] line_emph_amount;
    wire logic [9:0] line_edge_ps;
    wire logic [7:0] host_deemph_tenth_db;
    wire logic rx_a, rx_b, rx_host, pin;
    int num_errors = 0, n_compared = 0, cyc = 0;
    logic [31:0] rd;
    logic er;
    logic [2:0] cmp_tab [4] = '{`ODSC_CMP_LOW, `ODSC_CMP_RES, `ODSC_CMP_FLOAT, `ODSC_CMP_HIGH};
    logic [2:0] sel_tab [4] = '{3'b010, 3'b001, 3'b100, 3'b001};
    logic [9:0] edge_tab [5] = '{`ODSC_EDGE_12G, `ODSC_EDGE_6G, `ODSC_EDGE_3G,
        `ODSC_EDGE_1G5, `ODSC_EDGE_270M};
    odsc_top odsc_top_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .line_amplitude_strap, .mode_strap, .recovered_data,
        .clock_recovery_locked, .detected_rate, .reclock_bypass, .signal_found_n,
        .adapt_done, .input_lost, .eye_low, .line_out_a, .line_out_b, .host_loopback_out,
        .output_swing_level, .line_nominal_mv, .line_emph_en, .line_emph_amount,
        .line_edge_ps, .host_swing_mv, .host_deemph_tenth_db, .status_out, .status_oe,
        .spi_select, .smbus_select, .mode_reserved);
    odsc_partner odsc_partner_inst (.clk, .line_out_a, .line_out_b, .host_loopback_out,
        .status_out, .status_oe, .rx_a, .rx_b, .rx_host, .pin);
    always #4 clk = ~clk;
    // A data pattern that is not a plain toggle, so a stuck lane is seen
    always @(posedge clk) begin
        cyc <= cyc + 1;
        recovered_data <= cyc[0] ^ cyc[2];
        if (cyc == 30000) begin
            num_errors++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end
    task close_out;
        $display("Compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer; only the bench timeout ends a hung wait
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (4) @(posedge clk);
    endtask
    task settle(input int k);
        repeat (k) @(posedge clk);
    endtask
    initial begin
        // Straps are taken once after reset, so each level needs its own reset
        for (int i = 0; i < 4; i++) begin
            line_amplitude_strap <= cmp_tab[i];
            mode_strap <= cmp_tab[i];
            rst <= 1'b1;
            settle(6);
            rst <= 1'b0;
            settle(3);
            chk(output_swing_level, i);
            chk({spi_select, smbus_select, mode_reserved}, sel_tab[i]);
            chk(line_nominal_mv, `ODSC_LINE_NOM_MV);
            chk({host_deemph_tenth_db, host_swing_mv}, 20'h0423a);
        end
        apb(1'b0, 12'h0fc, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        wr(`ODSC_ADDR_LINE, 32'h0000_0007);
        wr(`ODSC_ADDR_NOM, 32'h0000_0384);
        chk(output_swing_level, 2'h3);
        chk(line_nominal_mv, 12'h384);
        for (int j = 0; j < 2; j++) begin
            wr(`ODSC_ADDR_LINE, j ? 32'h0000_6900 : 32'h0000_1900);
            for (int k = 0; k < 6; k++) begin
                settle(1);
                chk({rx_a ^ rx_host, rx_b ^ rx_host}, 2'b10);
            end
        end
        for (int r = 0; r < 5; r++) begin
            clock_recovery_locked <= 1'b0;
            detected_rate <= r;
            settle(2);
            clock_recovery_locked <= 1'b1;
            settle(5);
            chk(line_emph_en, r < 2);
            chk(line_edge_ps, edge_tab[r]);
            chk(pin, 1'b0);
            if (r == 0) chk(line_emph_amount, 4'h9);
        end
        detected_rate <= `ODSC_RATE_12G;
        settle(5);
        chk(line_edge_ps, `ODSC_EDGE_12G);
        chk(line_emph_en, 1'b1);
        clock_recovery_locked <= 1'b0;
        settle(3);
        chk(pin, 1'b1);
        clock_recovery_locked <= 1'b1;
        wr(`ODSC_ADDR_LINE, 32'h0000_0010);
        chk(line_emph_en, 1'b0);
        wr(`ODSC_ADDR_LINE, 32'h0000_0030);
        chk(line_emph_en, 1'b1);
        reclock_bypass <= 1'b1;
        wr(`ODSC_ADDR_EDGE, 32'h0000_00aa);
        wr(`ODSC_ADDR_LINE, 32'h0000_0020);
        chk(line_edge_ps, 10'h0aa);
        chk(line_emph_en, 1'b1);
        wr(`ODSC_ADDR_LINE, 32'h0000_0000);
        chk(line_emph_en, 1'b0);
        reclock_bypass <= 1'b0;
        wr(`ODSC_ADDR_HOST, 32'h800c_01f4);
        chk({host_deemph_tenth_db, host_swing_mv}, 20'h0c1f4);
        wr(`ODSC_ADDR_HOST, 32'h000c_01f4);
        chk({host_deemph_tenth_db, host_swing_mv}, 20'h0423a);
        wr(`ODSC_ADDR_STAT, 32'h0000_0001);
        signal_found_n <= 1'b0;
        settle(3);
        chk(pin, 1'b1);
        adapt_done <= 1'b1;
        settle(3);
        chk(pin, 1'b0);
        // With every mask off an event must leave the pin released
        wr(`ODSC_ADDR_STAT, 32'h0000_0002);
        input_lost <= 1'b1;
        settle(4);
        chk(pin, 1'b1);
        input_lost <= 1'b0;
        settle(2);
        for (int i = 0; i < 5; i++) begin
            wr(`ODSC_ADDR_STAT, 32'h2 | (32'h10 << i));
            case (i)
                0: input_lost <= 1'b1;
                1: input_lost <= 1'b0;
                2: eye_low <= 1'b1;
                3: begin
                    eye_low <= 1'b0;
                    clock_recovery_locked <= 1'b0;
                    settle(2);
                    clock_recovery_locked <= 1'b1;
                end
                default: clock_recovery_locked <= 1'b0;
            endcase
            settle(4);
            chk(pin, 1'b0);
            apb(1'b0, `ODSC_ADDR_INT, 32'h0);
            chk(rd, 32'h1 << i);
            settle(3);
            chk(pin, 1'b1);
        end
        close_out();
    end
endmodule // testbench
`default_nettype wire
